// file: verilog/rsac_cfg.svh
// constants for the gain-lock and synthesizer table configuration block
`ifndef RSAC_CFG_SVH
`define RSAC_CFG_SVH
// register indices
`define RSAC_ADDR_TABLE_CFG  4'h0
`define RSAC_ADDR_TUNE_A     4'h1
`define RSAC_ADDR_STATUS     4'h2
// field positions inside the table configuration register
`define RSAC_GAIN_HI         7
`define RSAC_GAIN_LO         6
`define RSAC_SRC_HI          5
`define RSAC_SRC_LO          4
`define RSAC_TUNEB_HI        3
`define RSAC_TUNEB_LO        0
// tune-a field sits in bits 7:2 of its register
`define RSAC_TUNEA_HI        7
`define RSAC_TUNEA_LO        2
// reset values
`define RSAC_RST_TABLE_CFG   8'h00
`define RSAC_RST_TUNE_A      6'h00
// custom transmit table window in packet RAM
`define RSAC_TX_TABLE_FIRST  8'h10
`define RSAC_TX_TABLE_LAST   8'h18
`endif

// file: verilog/rsac_pkg.sv
// types for the gain-lock and synthesizer table configuration block
package rsac_pkg;
  typedef enum logic [1:0] {
    RSAC_GAIN_FREE   = 2'h0,
    RSAC_GAIN_MANUAL = 2'h1,
    RSAC_GAIN_HOLD   = 2'h2,
    RSAC_GAIN_SYNC   = 2'h3
  } rsac_gain_mode_t;

  typedef enum logic [1:0] {
    RSAC_SRC_ROM     = 2'h0,
    RSAC_SRC_RX_CUST = 2'h1,
    RSAC_SRC_TX_CUST = 2'h2,
    RSAC_SRC_BOTH    = 2'h3
  } rsac_table_src_t;

  typedef struct packed {
    rsac_gain_mode_t gain_lock_select;
    rsac_table_src_t loop_table_source;
    logic [3:0]      rx_loop_tune_b;
  } rsac_table_cfg_t;

  typedef struct packed {
    logic       custom_table;
    logic       narrow_band;
    logic [5:0] tune_a;
    logic [3:0] tune_b;
  } rsac_loop_sel_t;
endpackage : rsac_pkg

// file: verilog/rsac_config.sv
// gain-lock and synthesizer loop-table configuration register bank
//
// Summary of operation
// - gain lock field: 0 free, 1 manual, 2 hold, 3 lock on sync word
// - sync-word gain lock acts only while preamble match setting is zero
// - rom choice: narrow band in receive, rate/modulation based in transmit
// - source 0: rom tables for both transmit and receive on state entry
// - source 1: custom receive table from tune fields, rom transmit table
// - source 3: custom receive and custom transmit tables
// - source 1 or 3: tune field b trims receive loop bandwidth
`include "rsac_cfg.svh"
`timescale 1ns/10ps
`default_nettype none

module rsac_config #(
  parameter int ADDR_W = 4
) (
  input  wire logic              i_clk_sys,
  input  wire logic              i_sys_rst,
  input  wire logic [ADDR_W-1:0] i_addr,
  input  wire logic [7:0]        i_wdata,
  input  wire logic              i_wr,
  input  wire logic              i_rd,
  output logic      [7:0]        o_rdata,
  input  wire logic              i_preamble_match_zero,
  input  wire logic              i_enter_tx,
  input  wire logic              i_enter_rx,
  input  wire logic              i_sync_word_det,
  output logic      [1:0]        o_gain_mode,
  output logic                   o_gain_frozen,
  output logic                   o_gain_manual,
  output logic                   o_rx_custom,
  output logic                   o_tx_custom,
  output logic      [7:0]        o_tx_table_base,
  output logic      [7:0]        o_tx_table_last,
  output rsac_pkg::rsac_loop_sel_t o_loop_sel,
  output logic                   o_loop_load
);

  // ==========================================================
  // registers
  rsac_pkg::rsac_table_cfg_t cfg;
  logic [5:0]                tune_a;
  logic                      sync_locked;
  logic                      in_tx;

  function automatic logic rx_custom_of(input rsac_pkg::rsac_table_src_t s);
    rx_custom_of = (s == rsac_pkg::RSAC_SRC_RX_CUST) || (s == rsac_pkg::RSAC_SRC_BOTH);
  endfunction : rx_custom_of

  function automatic logic tx_custom_of(input rsac_pkg::rsac_table_src_t s);
    tx_custom_of = (s == rsac_pkg::RSAC_SRC_TX_CUST) || (s == rsac_pkg::RSAC_SRC_BOTH);
  endfunction : tx_custom_of

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      cfg <= `RSAC_RST_TABLE_CFG;
    end else if (i_wr && i_addr == `RSAC_ADDR_TABLE_CFG) begin
      cfg <= i_wdata;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      tune_a <= `RSAC_RST_TUNE_A;
    end else if (i_wr && i_addr == `RSAC_ADDR_TUNE_A) begin
      tune_a <= i_wdata[`RSAC_TUNEA_HI:`RSAC_TUNEA_LO];
    end
  end

  // ==========================================================
  // bus read, data one cycle after the strobe; unmapped reads zero
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      o_rdata <= 8'h00;
    end else if (i_rd) begin
      case (i_addr)
        `RSAC_ADDR_TABLE_CFG: o_rdata <= cfg;
        `RSAC_ADDR_TUNE_A:    o_rdata <= {tune_a, 2'h0};
        `RSAC_ADDR_STATUS:    o_rdata <= {4'h0, in_tx, sync_locked, o_gain_frozen, o_gain_manual};
        default:              o_rdata <= 8'h00;
      endcase
    end else begin
      o_rdata <= 8'h00;
    end
  end

  // ==========================================================
  // gain lock
  // lock clears on receive entry unless a sync word is detected in the same cycle, so each packet relocks
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      sync_locked <= 1'b0;
    end else if (cfg.gain_lock_select != rsac_pkg::RSAC_GAIN_SYNC || !i_preamble_match_zero) begin
      sync_locked <= 1'b0;
    end else if (i_sync_word_det) begin
      sync_locked <= 1'b1;
    end else if (i_enter_rx) begin
      sync_locked <= 1'b0;
    end
  end

  always_comb begin
    o_gain_mode   = cfg.gain_lock_select;
    o_gain_manual = 1'b0;
    o_gain_frozen = 1'b0;
    case (cfg.gain_lock_select)
      rsac_pkg::RSAC_GAIN_FREE:   o_gain_frozen = 1'b0;
      rsac_pkg::RSAC_GAIN_MANUAL: o_gain_manual = 1'b1;
      rsac_pkg::RSAC_GAIN_HOLD:   o_gain_frozen = 1'b1;
      rsac_pkg::RSAC_GAIN_SYNC:   o_gain_frozen = sync_locked;
      default:                    o_gain_frozen = 1'b0;
    endcase
  end

  // ==========================================================
  // loop table selection, latched on each transmit or receive entry
  assign o_rx_custom     = rx_custom_of(cfg.loop_table_source);
  assign o_tx_custom     = tx_custom_of(cfg.loop_table_source);
  assign o_tx_table_base = `RSAC_TX_TABLE_FIRST;
  assign o_tx_table_last = `RSAC_TX_TABLE_LAST;

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      in_tx <= 1'b0;
    end else if (i_enter_tx) begin
      in_tx <= 1'b1;
    end else if (i_enter_rx) begin
      in_tx <= 1'b0;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      o_loop_sel  <= '0;
      o_loop_load <= 1'b0;
    end else begin
      o_loop_load <= i_enter_tx || i_enter_rx;
      if (i_enter_tx) begin
        // transmit: custom table from packet ram, else rom by rate/modulation
        o_loop_sel.custom_table <= tx_custom_of(cfg.loop_table_source);
        o_loop_sel.narrow_band  <= 1'b0;
        o_loop_sel.tune_a       <= 6'h00;
        o_loop_sel.tune_b       <= 4'h0;
      end else if (i_enter_rx) begin
        o_loop_sel.custom_table <= rx_custom_of(cfg.loop_table_source);
        o_loop_sel.narrow_band  <= !rx_custom_of(cfg.loop_table_source);
        // tune fields only reach the loop in custom receive modes
        o_loop_sel.tune_a       <= rx_custom_of(cfg.loop_table_source) ? tune_a : 6'h00;
        o_loop_sel.tune_b       <= rx_custom_of(cfg.loop_table_source) ? cfg.rx_loop_tune_b : 4'h0;
      end
    end
  end

endmodule : rsac_config

`default_nettype wire

// file: testbench/rsac_config_sva.sv
// assertion checker for the table configuration block
`timescale 1ns/10ps
`default_nettype none
module rsac_chk_sva (
  input wire logic                     i_clk_sys,
  input wire logic                     i_sys_rst,
  input wire logic                     i_wr,
  input wire logic                     i_enter_tx,
  input wire logic                     i_enter_rx,
  input wire logic                     i_sync_word_det,
  input wire logic                     i_preamble_match_zero,
  input wire logic [1:0]               o_gain_mode,
  input wire logic                     o_gain_frozen,
  input wire logic                     o_gain_manual,
  input wire logic                     o_rx_custom,
  input wire logic                     o_tx_custom,
  input wire logic [7:0]               o_tx_table_base,
  input wire logic [7:0]               o_tx_table_last,
  input wire rsac_pkg::rsac_loop_sel_t o_loop_sel,
  input wire logic                     o_loop_load
);
  // ==========
  // properties
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_sys_rst);
  gain_manual_a: assert property (o_gain_manual == (o_gain_mode == 2'h1)) else $error("manual flag");
  hold_frozen_a: assert property (o_gain_mode == 2'h2 |-> o_gain_frozen) else $error("hold");
  sync_lock_a: assert property (o_gain_mode == 2'h3 && i_preamble_match_zero && i_sync_word_det |=>
    o_gain_mode != 2'h3 || !i_preamble_match_zero || o_gain_frozen) else $error("sync lock");
  preamble_gate_a: assert property (o_gain_mode == 2'h3 && !i_preamble_match_zero &&
    $past(!i_preamble_match_zero) |-> !o_gain_frozen) else $error("preamble gate");
  rx_select_a: assert property (i_enter_rx && !i_enter_tx && !i_wr |=> o_loop_load &&
    o_loop_sel.custom_table == o_rx_custom && o_loop_sel.narrow_band != o_rx_custom) else $error("rx sel");
  tx_select_a: assert property (i_enter_tx && !i_wr |=> o_loop_load &&
    o_loop_sel.custom_table == o_tx_custom && !o_loop_sel.narrow_band) else $error("tx sel");
  rom_tune_a: assert property (o_loop_load && !o_loop_sel.custom_table |-> o_loop_sel[9:0] == 10'h0) else $error("tune");
  tbl_window_a: assert property (o_tx_table_base == 8'h10 && o_tx_table_last == 8'h18) else $error("window");
endmodule : rsac_chk_sva
bind rsac_config rsac_chk_sva u_chk (.*);
`default_nettype wire

// file: testbench/tb_top.sv
// self-checking bench for the table configuration block
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic i_clk_sys = 0, i_sys_rst = 1, i_wr = 0, i_rd = 0, i_enter_tx = 0, i_enter_rx = 0;
  logic i_sync_word_det = 0, i_preamble_match_zero = 0, o_gain_frozen, o_gain_manual;
  logic o_rx_custom, o_tx_custom, o_loop_load;
  logic [3:0] i_addr = 4'h0;
  logic [7:0] i_wdata = 8'h00, o_rdata, o_tx_table_base, o_tx_table_last;
  logic [1:0] o_gain_mode;
  rsac_pkg::rsac_loop_sel_t o_loop_sel;
  int miscompares = 0, checks_done = 0;
  rsac_config #(.ADDR_W(4)) uut (.*);
  // ==========
  // bus, state-entry, sync-word and compare tasks
  task automatic cmp(input logic [12:0] got, input logic [12:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_clk_sys);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk_sys);
    i_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge i_clk_sys);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk_sys);
    i_rd <= 1'b0;
    #1 cmp(o_rdata, e);
  endtask : rd
  task automatic ent(input logic tx, input logic [11:0] e);
    @(posedge i_clk_sys);
    i_enter_tx <= tx;
    i_enter_rx <= !tx;
    @(posedge i_clk_sys);
    i_enter_tx <= 1'b0;
    i_enter_rx <= 1'b0;
    #1 cmp({o_loop_load, o_loop_sel}, {1'b1, e});
  endtask : ent
  task automatic sy(input logic p, input logic e);
    @(posedge i_clk_sys);
    i_preamble_match_zero <= p;
    i_sync_word_det <= 1'b1;
    @(posedge i_clk_sys);
    i_sync_word_det <= 1'b0;
    #1 cmp(o_gain_frozen, e);
  endtask : sy
  task automatic close_out();
    if (miscompares == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : close_out
  initial begin
    forever #12.5 i_clk_sys = ~i_clk_sys;
  end
  // whole run is a few hundred cycles
  initial begin
    #50000 miscompares++;
    close_out();
  end
  initial begin
    logic [7:0] c;
    logic [5:0] ta;
    void'($urandom(92));
    repeat (2) @(posedge i_clk_sys);
    i_sys_rst <= 1'b0;
    rd(4'h0, 8'h00);
    rd(4'h7, 8'h00);
    for (int k = 0; k < 16; k++) begin
      c[7:4] = k[3:0];
      c[3:0] = c[4] ? 4'($urandom) : 4'h0;
      ta = c[4] ? 6'($urandom) : 6'h0;
      wr(4'h0, c);
      wr(4'h1, {ta, 2'h3});
      rd(4'h0, c);
      rd(4'h1, {ta, 2'h0});
      cmp({o_gain_mode, o_gain_manual, o_gain_frozen, o_rx_custom, o_tx_custom},
          {c[7:6], c[7:6] == 2'h1, c[7:6] == 2'h2, c[4], c[5]});
      ent(1'b0, {c[4], !c[4], c[4] ? {ta, c[3:0]} : 10'h0});
      ent(1'b1, {c[5], 11'h0});
    end
    wr(4'h0, 8'hC0);
    sy(1'b0, 1'b0);
    sy(1'b1, 1'b1);
    rd(4'h2, 8'h0E);
    cmp(o_tx_table_base, 8'h10);
    cmp(o_tx_table_last, 8'h18);
    ent(1'b0, 12'h400);
    cmp(o_gain_frozen, 1'b0);
    close_out();
  end
endmodule : tb_top
`default_nettype wire
